// File: rtl/conv_timing_pkg.sv
/*
  Shared constants and carrier types for the conversion timing control block.
  Assumes a 32-bit APB register bus running on the 100 MHz bus clock.
*/
package conv_timing_pkg;

  // Register byte offsets.
  localparam logic [11:0] TIMING_CTRL_OFS = 12'h000;
  localparam logic [11:0] SEQ_START_OFS = 12'h004;
  localparam logic [11:0] SEQ_STATUS_OFS = 12'h008;

  // Field positions in the timing control register.
  localparam int RES_SEL_BIT = 7;
  localparam int SAMPLE_LEN_LSB = 5;
  localparam int PRESCALE_LSB = 0;

  // Reset value: 10-bit resolution, shortest sample, prescale 5.
  localparam logic [7:0] TIMING_CTRL_RST = 8'h05;

  // First sample phase length and conversion bit counts in conversion clocks.
  localparam logic [4:0] PHASE1_CYCLES = 5'h02;
  localparam logic [4:0] BITS_10 = 5'h0A;
  localparam logic [4:0] BITS_8 = 5'h08;

  // Second sample phase length for each field code, in conversion clocks.
  localparam logic [4:0] SAMPLE_LEN_CODE0 = 5'h02;
  localparam logic [4:0] SAMPLE_LEN_CODE1 = 5'h04;
  localparam logic [4:0] SAMPLE_LEN_CODE2 = 5'h08;
  localparam logic [4:0] SAMPLE_LEN_CODE3 = 5'h10;

  // Bus clock period and nominal conversion clock limits.
  localparam int BUS_CLK_PERIOD_NS = 10;
  localparam int CONV_CLK_MAX_KHZ = 2000;
  localparam int CONV_CLK_MIN_KHZ = 500;

  // Settings captured at sequence start and handed to the sequencer.
  typedef struct packed {
    logic resolution_select;
    logic [1:0] sample_phase_length;
    logic [4:0] clock_prescale;
  } timing_cfg_t;

  // Conversion sequencer phases.
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SAMPLE1 = 4'b0010,
    ST_SAMPLE2 = 4'b0100,
    ST_CONVERT = 4'b1000
  } seq_state_t;

endpackage : conv_timing_pkg

// File: rtl/conv_clk_prescaler.sv
/*
  Conversion clock prescaler producing one-cycle ticks at bus/(2*(prescale+1)).
  Assumes restart is pulsed when a sequence starts so the phase is known.
*/
`timescale 1ns/1ps
`default_nettype none
module conv_clk_prescaler
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Control.
  input wire logic restart,
  input wire logic run,
  input wire logic [4:0] prescale,
  // Tick output.
  output logic tick
);
  import conv_timing_pkg::*;

  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic [5:0] last;

  // Full divisor 2*(prescale+1); terminal count is that minus one.
  assign last = {prescale, 1'b1}; // [RULE_07]

  // The tick is decoded from the counter, not registered, so the first
  // conversion clock after a restart is a whole divisor long and not longer.
  assign tick = run && !restart && (cnt_r == last); // [RULE_07]

  // Counter restarts on demand so a new sequence begins on a clean edge.
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (restart || !run)
    begin
      cnt_nxt = 6'h00; // [RULE_11]
    end
    else if (cnt_r == last)
    begin
      cnt_nxt = 6'h00;
    end
    else
    begin
      cnt_nxt = cnt_r + 6'h01;
    end
  end

  // Register stage.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= 6'h00;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule : conv_clk_prescaler
`default_nettype wire

// File: rtl/conv_timing_ctrl.sv
/*
  Timing control register and conversion sequence timer of the A/D converter.
  Assumes an APB master on pclk; analog front end follows the phase outputs.
*/
// Decided for this implementation: register access over APB and the register addresses.
// Function
// [RULE_01] Any timing control write aborts a running sequence, never starts one.
// [RULE_02] Timing control register is readable and writable at any time.
// [RULE_03] Bit 7 picks resolution: 0 gives 10-bit, 1 gives 8-bit.
// [RULE_04] 8-bit conversions take fewer conversion clocks than 10-bit ones.
// [RULE_05] Sample phase one lasts two conversion clocks via buffer amplifier.
// [RULE_06] Sample length field gives 2, 4, 8 or 16 second-phase clocks.
// [RULE_07] Conversion clock is bus clock divided by 2*(prescale+1).
// [RULE_08] Prescale field resets to 5, giving bus clock divided by 12.
// [RULE_09] Software keeps conversion clock between 500 kHz and 2 MHz.
// [RULE_10] Only a sequence start write starts a sequence, aborting any running.
// [RULE_11] New settings apply from the next started sequence, prescaler restarted.
`timescale 1ns/1ps
`default_nettype none
module conv_timing_ctrl
(
  // APB slave.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sequence timing outputs.
  output logic busy,
  output logic sample_buffered,
  output logic sample_direct,
  output logic converting,
  output logic conv_done,
  output logic seq_aborted,
  output conv_timing_pkg::timing_cfg_t active_cfg
);
  import conv_timing_pkg::*;

  // Register state.
  timing_cfg_t ctrl_r;
  timing_cfg_t ctrl_nxt;
  timing_cfg_t act_r;
  timing_cfg_t act_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic aborted_r;
  logic aborted_nxt;
  logic done_r;
  logic done_nxt;
  seq_state_t st_r;
  seq_state_t st_nxt;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic busy_r;
  logic busy_nxt;

  // Decoded strobes.
  logic setup;
  logic wr_timing;
  logic wr_start;
  logic tick;
  logic [4:0] phase2_len;
  logic [4:0] bit_len;

  // Bus requests are taken in the setup cycle and answered one cycle later.
  assign setup = psel && !penable && !pready_r;
  assign wr_timing = setup && pwrite && (paddr == TIMING_CTRL_OFS); // [RULE_02]
  assign wr_start = setup && pwrite && (paddr == SEQ_START_OFS);

  // Second sample phase length from the captured field.
  always_comb
  begin
    case (act_r.sample_phase_length)
      2'b00: phase2_len = SAMPLE_LEN_CODE0; // [RULE_06]
      2'b01: phase2_len = SAMPLE_LEN_CODE1;
      2'b10: phase2_len = SAMPLE_LEN_CODE2;
      default: phase2_len = SAMPLE_LEN_CODE3;
    endcase
  end

  // Fewer successive approximation steps in 8-bit mode shorten the conversion.
  assign bit_len = act_r.resolution_select ? BITS_8 : BITS_10; // [RULE_03] [RULE_04]

  // Prescaler restarts in the very cycle a start is taken, so every phase
  // of the sequence is a whole number of conversion clocks long.
  conv_clk_prescaler i_conv_clk_prescaler
  (
    .pclk(pclk),
    .presetn(presetn),
    .restart(wr_start), // [RULE_11]
    .run(busy_r),
    .prescale(act_r.clock_prescale),
    .tick(tick)
  );

  // APB register file; reads are side-effect free.
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    prdata_nxt = prdata_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    if (setup)
    begin
      pready_nxt = 1'b1;
      prdata_nxt = 32'h0000_0000;
      if (paddr == TIMING_CTRL_OFS)
      begin
        prdata_nxt = {24'h00_0000, ctrl_r};
        if (pwrite)
        begin
          ctrl_nxt = timing_cfg_t'(pwdata[7:0]);
        end
      end
      else if (paddr == SEQ_START_OFS)
      begin
        prdata_nxt = 32'h0000_0000;
      end
      else if (paddr == SEQ_STATUS_OFS)
      begin
        prdata_nxt = {27'h000_0000, done_r, aborted_r, st_r == ST_CONVERT,
                      st_r == ST_SAMPLE2 || st_r == ST_SAMPLE1, st_r != ST_IDLE};
      end
      else
      begin
        pslverr_nxt = 1'b1; // Unmapped address.
      end
    end
  end

  // Sequencer: sample phase one, phase two, then conversion steps.
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    act_nxt = act_r;
    aborted_nxt = aborted_r;
    done_nxt = done_r;
    if (wr_start)
    begin
      // A start also aborts anything running and latches fresh settings.
      act_nxt = wr_timing ? timing_cfg_t'(pwdata[7:0]) : ctrl_r; // [RULE_11]
      st_nxt = ST_SAMPLE1; // [RULE_10]
      cnt_nxt = PHASE1_CYCLES;
      aborted_nxt = (st_r != ST_IDLE);
      done_nxt = 1'b0;
    end
    else if (wr_timing)
    begin
      // Abort only; the sequencer waits for an explicit start.
      aborted_nxt = aborted_r || (st_r != ST_IDLE);
      st_nxt = ST_IDLE; // [RULE_01]
      cnt_nxt = 5'h00;
    end
    else if (tick)
    begin
      case (st_r)
        ST_SAMPLE1:
        begin
          if (cnt_r == 5'h01)
          begin
            st_nxt = ST_SAMPLE2; // [RULE_05]
            cnt_nxt = phase2_len;
          end
          else
          begin
            cnt_nxt = cnt_r - 5'h01;
          end
        end
        ST_SAMPLE2:
        begin
          if (cnt_r == 5'h01)
          begin
            st_nxt = ST_CONVERT;
            cnt_nxt = bit_len;
          end
          else
          begin
            cnt_nxt = cnt_r - 5'h01;
          end
        end
        ST_CONVERT:
        begin
          if (cnt_r == 5'h01)
          begin
            st_nxt = ST_IDLE;
            done_nxt = 1'b1;
          end
          else
          begin
            cnt_nxt = cnt_r - 5'h01;
          end
        end
        default:
        begin
          st_nxt = ST_IDLE;
        end
      endcase
    end
  end

  // Register stage.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= timing_cfg_t'(TIMING_CTRL_RST); // [RULE_08]
      act_r <= timing_cfg_t'(TIMING_CTRL_RST);
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      st_r <= ST_IDLE;
      cnt_r <= 5'h00;
      busy_r <= 1'b0;
      aborted_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      act_r <= act_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
      aborted_r <= aborted_nxt;
      done_r <= done_nxt;
    end
  end

  // Busy is registered from the next state, so the pin carries no decode.
  assign busy_nxt = st_nxt != ST_IDLE;

  // Outputs straight from flip-flops.
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign busy = busy_r;
  assign sample_buffered = st_r[1];
  assign sample_direct = st_r[2];
  assign converting = st_r[3];
  assign conv_done = done_r;
  assign seq_aborted = aborted_r;
  assign active_cfg = act_r;

endmodule : conv_timing_ctrl
`default_nettype wire

// File: tb/conv_timing_props.sv
/* Port checker for conv_timing_ctrl.
   Assumes one clock domain and that it is bound to every instance. */
`timescale 1ns/1ps
`default_nettype none
module conv_timing_props
(
  // Bus side.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  // Sequence side.
  input wire logic busy,
  input wire logic sample_buffered,
  input wire logic sample_direct,
  input wire logic converting,
  input wire logic conv_done,
  input wire logic seq_aborted,
  input wire conv_timing_pkg::timing_cfg_t active_cfg
);
  import conv_timing_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup-phase writes to the two control registers.
  wire tw = psel && !penable && pwrite && paddr == TIMING_CTRL_OFS;
  wire sw = psel && !penable && pwrite && paddr == SEQ_START_OFS;
  wire [2:0] ph = {sample_buffered, sample_direct, converting};
  // Bus clocks per conversion clock, second-phase clocks and conversion clocks.
  wire [11:0] d = 12'h002 * (active_cfg.clock_prescale + 12'h001);
  wire [4:0] s2 = 5'h02 << active_cfg.sample_phase_length;
  wire [3:0] cv = active_cfg.resolution_select ? 4'h8 : 4'hA;
  logic [2:0] ph_r;
  logic [11:0] n_r;
  logic sw_r;
  // Run length of the last phase; lengths are judged on the cycle it ends.
  // A start while sampling begins the phase afresh, so the count restarts too.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ph_r <= 3'h0;
      n_r <= 12'h000;
      sw_r <= 1'b0;
    end
    else
    begin
      ph_r <= ph;
      sw_r <= sw;
      n_r <= (ph == ph_r && !sw_r) ? n_r + 12'h001 : 12'h001;
    end
  end
  a_bus_answer: assert property (psel && !penable |=> pready)
    else $error("access not answered");
  a_write_aborts: assert property (tw && busy |=> !busy && seq_aborted)
    else $error("timing write did not abort");
  a_write_nostart: assert property (tw && !busy |=> !busy)
    else $error("timing write started a sequence");
  a_start_runs: assert property (sw |=> sample_buffered && busy)
    else $error("start did not begin sampling");
  a_idle_holds: assert property (!busy && !sw |=> !busy)
    else $error("sequence began without start");
  a_reset_cfg: assert property ($rose(presetn) |-> active_cfg == TIMING_CTRL_RST)
    else $error("wrong settings after reset");
  a_phase1_len: assert property (ph_r == 3'h4 && ph == 3'h2 |-> n_r == 2 * d)
    else $error("first sample phase length");
  a_phase2_len: assert property (ph_r == 3'h2 && ph == 3'h1 |-> n_r == d * s2)
    else $error("second sample phase length");
  a_conv_len: assert property (ph_r == 3'h1 && !ph && conv_done |-> n_r == d * cv)
    else $error("conversion length");
  c_abort: cover property (tw && busy);
  c_done8: cover property (ph_r == 3'h1 && !ph && conv_done && active_cfg.resolution_select);
  c_start: cover property (sw && !busy);
endmodule : conv_timing_props
bind conv_timing_ctrl conv_timing_props i_conv_timing_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .busy(busy),
  .sample_buffered(sample_buffered), .sample_direct(sample_direct), .converting(converting),
  .conv_done(conv_done), .seq_aborted(seq_aborted), .active_cfg(active_cfg));
`default_nettype wire

// File: tb/tb_top.sv
/* Self-checking bench for conv_timing_ctrl.
   Assumes the APB answer of one wait-free access cycle and idle outputs at rest. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import conv_timing_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic busy, sample_buffered, sample_direct, converting, conv_done, seq_aborted;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  timing_cfg_t active_cfg;
  int miscompares, num_checks, nb, nd, nc;
  conv_timing_ctrl i_conv_timing_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .busy(busy), .sample_buffered(sample_buffered),
    .sample_direct(sample_direct), .converting(converting), .conv_done(conv_done),
    .seq_aborted(seq_aborted), .active_cfg(active_cfg));
  // Bus clock.
  initial
  begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  // Phase occupancy; an idle sequencer adds nothing, so clearing needs no sync.
  always @(posedge pclk)
  begin
    nb += sample_buffered;
    nd += sample_direct;
    nc += converting;
  end
  task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  // One APB transfer; request held until pready is sampled high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
    int i;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1'h1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'h1 && i < 20);
    if (pready !== 1'h1)
    begin
      miscompares++;
      tally_and_finish;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task reset_vals;
    apb(1'h0, TIMING_CTRL_OFS, 32'h0);
    check("timing", rd, 32'h05);
    check("cfg", 32'(active_cfg), 32'h05);
    apb(1'h0, 12'h00C, 32'h0);
    check("unmapped", {er, rd[30:0]}, 32'h80000000);
  endtask : reset_vals
  task abort_seq;
    apb(1'h1, TIMING_CTRL_OFS, 32'h1F);
    apb(1'h1, SEQ_START_OFS, 32'h0);
    repeat (20) @(posedge pclk);
    check("busy", 32'(busy), 32'h1);
    apb(1'h1, TIMING_CTRL_OFS, 32'hB8);
    check("abort", 32'({busy, seq_aborted, conv_done}), 32'h2);
    check("cfg hold", 32'(active_cfg), 32'h1F);
    apb(1'h0, SEQ_STATUS_OFS, 32'h0);
    check("status", rd, 32'h8);
    apb(1'h0, TIMING_CTRL_OFS, 32'h0);
    check("readback", rd, 32'hB8);
    repeat (200) @(posedge pclk);
    check("no start", 32'(busy), 32'h0);
  endtask : abort_seq
  // Full sequence; every phase length follows from the prescale divisor.
  task run_seq(input logic [7:0] cfg);
    int i;
    int dv;
    dv = 2 * (cfg[4:0] + 1);
    apb(1'h1, TIMING_CTRL_OFS, {24'h0, cfg});
    nb = 0;
    nd = 0;
    nc = 0;
    apb(1'h1, SEQ_START_OFS, 32'h0);
    i = 0;
    while (busy !== 1'h0 && i < 3000)
    begin
      @(posedge pclk);
      i++;
    end
    if (busy !== 1'h0)
    begin
      miscompares++;
      tally_and_finish;
    end
    check("phase1", nb, 2 * dv);
    check("phase2", nd, dv * (2 << cfg[6:5]));
    check("convert", nc, dv * (cfg[7] ? 8 : 10));
    check("cfg", 32'(active_cfg), {24'h0, cfg});
    check("done", 32'({seq_aborted, conv_done}), 32'h1);
  endtask : run_seq
  initial
  begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    reset_vals;
    abort_seq;
    // Prescale codes 24 to 31 keep the conversion clock in range at 100 MHz.
    run_seq(8'h18);
    run_seq(8'hB9);
    run_seq(8'h5A);
    run_seq(8'hFB);
    run_seq(8'h1F);
    tally_and_finish;
  end
endmodule : tb_top
`default_nettype wire
